// file: src/psel_top.sv
// Purpose: Prescaler mode and status pin selection registers with the status pin multiplexer.
// Assumes: Register writes arrive decoded from the serial control port, one byte per strobe.
// Notes: The status lock level is bit 7 of a register held elsewhere.
module psel_top
  import psel_pkg::*;
(
  input wire logic sys_clk, // System clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  input wire logic [9:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  output logic [7:0] reg_rdata, // Register read data, valid the cycle after reg_rd.
  input wire logic status_lock, // Status lock level; writes to the selection ignored when high.
  input wire logic vco_tick, // One pulse per feedback input edge.
  input wire logic swallow_nz, // Swallow count programmed nonzero.
  input wire logic swallow_phase, // Swallow counter asks for the plus-one modulus.
  input wire logic fb_div_out, // Feedback divider output after delay.
  input wire logic ref_div_out, // Reference divider output after delay.
  input wire logic swallow_out, // Swallow counter output.
  input wire logic pfd_up, // Phase detector up pulse.
  input wire logic pfd_down, // Phase detector down pulse.
  input wire logic ref1_clk, // First reference clock.
  input wire logic ref2_clk, // Second reference clock.
  input wire logic ref_sel_clk, // Reference selected to the loop.
  input wire logic ref_unsel_clk, // Reference not selected.
  output logic presc_out, // Prescaler output pulse.
  output logic [2:0] presc_mode, // Current prescaler mode.
  output logic [5:0] status_sel, // Current status selection.
  output logic status_pin // Status pin level.
);

  import psel_pkg::*;

  logic [2:0] mode_r;
  logic [5:0] sel_r;
  logic [7:0] rdata_r;
  logic pin_r;
  logic pin_nxt;
  logic wr_presc;
  logic wr_status;

  psel_div_if div_bus ();

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    wr_presc = 1'b0;
    wr_status = 1'b0;
    if (reg_wr && reg_addr == PSEL_PRESC_OFFS) begin
      wr_presc = 1'b1;
    end else if (reg_wr && reg_addr == PSEL_STATUS_OFFS) begin
      wr_status = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_r <= PSEL_MODE_RST;
    end else if (wr_presc) begin
      mode_r <= reg_wdata[PSEL_MODE_LSB +: 3];
    end
  end

  // A set lock freezes the selection so a pin in use cannot be switched by accident.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_r <= PSEL_SEL_RST;
    end else if (wr_status && !status_lock) begin
      sel_r <= reg_wdata[PSEL_SEL_LSB +: 6];
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Bits of these addresses that belong to other blocks read as zero here.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= PSEL_RDATA_RST;
    end else if (reg_rd) begin
      if (reg_addr == PSEL_PRESC_OFFS) begin
        rdata_r <= {5'h00, mode_r};
      end else if (reg_addr == PSEL_STATUS_OFFS) begin
        rdata_r <= {sel_r, 2'h0};
      end else begin
        rdata_r <= PSEL_RDATA_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign div_bus.mode = mode_r;
  assign div_bus.tick = vco_tick;
  assign div_bus.swallow_nz = swallow_nz;
  assign div_bus.use_plus1 = swallow_phase;

  psel_prescaler u_presc (
    .sys_clk(sys_clk),
    .srst(srst),
    .div(div_bus.div)
  );

  // ----------------------------------------------------------------
  // Status pin multiplexer
  // ----------------------------------------------------------------
  // Unlisted codes fall back to a level ground rather than leaving the pin undefined.
  always_comb begin
    case (sel_r)
      PSEL_ST_GND: pin_nxt = 1'b0;
      PSEL_ST_FBDIV: pin_nxt = fb_div_out;
      PSEL_ST_REFDIV: pin_nxt = ref_div_out;
      PSEL_ST_SWALLOW: pin_nxt = swallow_out;
      PSEL_ST_PRESC: pin_nxt = div_bus.presc_out;
      PSEL_ST_PFD_UP: pin_nxt = pfd_up;
      PSEL_ST_PFD_DN: pin_nxt = pfd_down;
      PSEL_ST_REF1: pin_nxt = ref1_clk;
      PSEL_ST_REF2: pin_nxt = ref2_clk;
      PSEL_ST_REF_SEL: pin_nxt = ref_sel_clk;
      PSEL_ST_REF_UNSEL: pin_nxt = ref_unsel_clk;
      default: pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign presc_out = div_bus.presc_out;
  assign presc_mode = mode_r;
  assign status_sel = sel_r;
  assign status_pin = pin_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode_reset: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> (mode_r == 3'h6 && presc_mode == 3'h6))
    else $error("prescaler mode not at its reset value");

  a_sel_reset: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> (sel_r == 6'h00) ##1 (!status_pin || sel_r != 6'h00))
    else $error("status selection not ground after reset");

  a_lock_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == 10'h017 && status_lock) |=> $stable(sel_r))
    else $error("status selection changed while locked");

  a_sel_write: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_wr && reg_addr == 10'h017 && !status_lock) |=> (sel_r == $past(reg_wdata[7:2])))
    else $error("status selection write lost");

  a_ground_pin: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h00 && !wr_status) [*2] |-> !status_pin)
    else $error("status pin not grounded");

  a_fb_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h01) |=> (status_pin == $past(fb_div_out)))
    else $error("feedback divider not routed to status pin");

  a_route_dyn: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h02 && ref_div_out) or (sel_r == 6'h03 && swallow_out)
    or (sel_r == 6'h05 && pfd_up) |=> status_pin)
    else $error("selected signal not routed to status pin");

  a_presc_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h04) |=> (status_pin == $past(presc_out)))
    else $error("prescaler output not routed to status pin");

  a_mode_write: assert property (@(posedge sys_clk)
    disable iff (srst) (reg_wr && reg_addr == 10'h016) |=> (presc_mode == $past(reg_wdata[2:0])))
    else $error("prescaler mode write lost");

  a_mode_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(reg_wr && reg_addr == 10'h016) |=> $stable(presc_mode))
    else $error("prescaler mode changed without a write");

  a_sel_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(reg_wr && reg_addr == 10'h017 && !status_lock) |=> $stable(status_sel))
    else $error("status selection changed without a write");

  a_read_mode: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == 10'h016) |=> (reg_rdata == {5'h00, $past(presc_mode)}))
    else $error("prescaler mode read back wrong");

  a_read_sel: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr == 10'h017) |=> (reg_rdata == {$past(status_sel), 2'h0}))
    else $error("status selection read back wrong");

  a_read_other: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_rd && reg_addr != 10'h016 && reg_addr != 10'h017) |=> (reg_rdata == 8'h00))
    else $error("unmapped address did not read as zero");

  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_refdiv_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h02) |=> (status_pin == $past(ref_div_out)))
    else $error("reference divider not routed to status pin");

  a_swallow_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h03) |=> (status_pin == $past(swallow_out)))
    else $error("swallow counter not routed to status pin");

  a_up_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h05) |=> (status_pin == $past(pfd_up)))
    else $error("up pulse not routed to status pin");

  a_down_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h06) |=> (status_pin == $past(pfd_down)))
    else $error("down pulse not routed to status pin");

  a_ref_route: assert property (@(posedge sys_clk) disable iff (srst)
    (sel_r == 6'h21 && ref1_clk) or (sel_r == 6'h22 && ref2_clk)
    or (sel_r == 6'h23 && ref_sel_clk) or (sel_r == 6'h24 && ref_unsel_clk) |=> status_pin)
    else $error("reference clock not routed to status pin");

  a_unlisted_gnd: assert property (@(posedge sys_clk) disable iff (srst)
    !(sel_r inside {[6'h01:6'h06], [6'h21:6'h24]}) |=> !status_pin)
    else $error("unlisted selection did not ground the status pin");

endmodule // psel_top

// file: src/psel_pkg.sv
// Purpose: Shared constants for the feedback prescaler and status pin select block.
// Assumes: One clock, synchronous active-high reset, byte-wide register port.
// Notes: One rule to a line below; the host side keeps the lock rule.
package psel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [9:0] PSEL_PRESC_OFFS = 10'h016;
  localparam logic [9:0] PSEL_STATUS_OFFS = 10'h017;
  localparam int PSEL_MODE_LSB = 0;
  localparam int PSEL_SEL_LSB = 2;
  localparam logic [2:0] PSEL_MODE_RST = 3'h6;
  localparam logic [5:0] PSEL_SEL_RST = 6'h00;
  localparam logic [7:0] PSEL_RDATA_RST = 8'h00;
  localparam logic [5:0] PSEL_CNT_RST = 6'h00;

  // ----------------------------------------------------------------
  // Prescaler modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSEL_FD_DIV1 = 3'h0,
    PSEL_FD_DIV2 = 3'h1,
    PSEL_DM_DIV2 = 3'h2,
    PSEL_DM_DIV4 = 3'h3,
    PSEL_DM_DIV8 = 3'h4,
    PSEL_DM_DIV16 = 3'h5,
    PSEL_DM_DIV32 = 3'h6,
    PSEL_FD_DIV3 = 3'h7
  } psel_mode_t;

  // ----------------------------------------------------------------
  // Status pin selection codes
  // ----------------------------------------------------------------
  localparam logic [5:0] PSEL_ST_GND = 6'h00;
  localparam logic [5:0] PSEL_ST_FBDIV = 6'h01;
  localparam logic [5:0] PSEL_ST_REFDIV = 6'h02;
  localparam logic [5:0] PSEL_ST_SWALLOW = 6'h03;
  localparam logic [5:0] PSEL_ST_PRESC = 6'h04;
  localparam logic [5:0] PSEL_ST_PFD_UP = 6'h05;
  localparam logic [5:0] PSEL_ST_PFD_DN = 6'h06;
  localparam logic [5:0] PSEL_ST_REF1 = 6'h21;
  localparam logic [5:0] PSEL_ST_REF2 = 6'h22;
  localparam logic [5:0] PSEL_ST_REF_SEL = 6'h23;
  localparam logic [5:0] PSEL_ST_REF_UNSEL = 6'h24;

  // Divide ratio for a mode; hi asks for the plus-one modulus.
  function automatic logic [5:0] psel_ratio(input logic [2:0] mode, input logic hi);
    logic [5:0] base;
    logic dual;
    base = 6'h01;
    dual = 1'b1;
    case (psel_mode_t'(mode))
      PSEL_FD_DIV1: begin
        base = 6'h01;
        dual = 1'b0;
      end
      PSEL_FD_DIV2: begin
        base = 6'h02;
        dual = 1'b0;
      end
      PSEL_DM_DIV2: base = 6'h02;
      PSEL_DM_DIV4: base = 6'h04;
      PSEL_DM_DIV8: base = 6'h08;
      PSEL_DM_DIV16: base = 6'h10;
      PSEL_DM_DIV32: base = 6'h20;
      default: begin
        base = 6'h03;
        dual = 1'b0;
      end
    endcase
    return base + {5'h00, dual & hi};
  endfunction

endpackage

// file: src/psel_div_if.sv
// Purpose: Carries prescaler control and output between the top and the divider.
// Assumes: Single clock domain.
// Notes: The controller side owns the mode and modulus request.
interface psel_div_if;
  logic [2:0] mode;
  logic tick;
  logic swallow_nz;
  logic use_plus1;
  logic presc_out;
  modport ctl (output mode, output tick, output swallow_nz, output use_plus1, input presc_out);
  modport div (input mode, input tick, input swallow_nz, input use_plus1, output presc_out);
endinterface // psel_div_if

// file: src/psel_prescaler.sv
// Purpose: Feedback prescaler counting input ticks and pulsing once per divide period.
// Assumes: tick is a one-cycle enable standing for one input clock edge.
// Notes: A mode change applies to the period in progress; a count already at or past the new end wraps on the next tick.
module psel_prescaler
  import psel_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  psel_div_if.div div // Mode in, prescaler pulse out.
);

  logic [5:0] cnt_r;
  logic out_r;
  logic [5:0] ratio;
  logic wrap;

  // The plus-one modulus applies only in dual modulus modes with a nonzero swallow count.
  assign ratio = psel_ratio(div.mode, div.swallow_nz & div.use_plus1);
  assign wrap = (cnt_r >= ratio - 6'h01);

  // ----------------------------------------------------------------
  // Divide counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= PSEL_CNT_RST;
    end else if (div.tick) begin
      cnt_r <= wrap ? PSEL_CNT_RST : cnt_r + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_r <= 1'b0;
    end else begin
      out_r <= div.tick & wrap;
    end
  end

  assign div.presc_out = out_r;

  // ----------------------------------------------------------------
  // Period checking helpers
  // ----------------------------------------------------------------
  logic [6:0] gap_r;
  logic [5:0] last_ratio_r;
  logic clean_r;
  logic [2:0] last_mode_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gap_r <= 7'h00;
      last_ratio_r <= PSEL_CNT_RST;
      clean_r <= 1'b1;
      last_mode_r <= PSEL_MODE_RST;
    end else begin
      if (out_r) begin
        gap_r <= {6'h00, div.tick};
      end else if (div.tick) begin
        gap_r <= gap_r + 7'h01;
      end
      if (div.tick) begin
        last_ratio_r <= ratio;
        last_mode_r <= div.mode;
      end
      if (out_r) begin
        clean_r <= 1'b1;
      end else if (div.tick && (ratio != last_ratio_r) && (gap_r != 7'h00)) begin
        clean_r <= 1'b0;
      end
    end
  end

  a_div_period: assert property (@(posedge sys_clk) disable iff (srst)
    (out_r && clean_r) |-> (gap_r == {1'b0, last_ratio_r}))
    else $error("prescaler period differs from selected ratio");

  a_dm_ratio_set: assert property (@(posedge sys_clk) disable iff (srst)
    (out_r && last_mode_r == 3'h4) |-> (last_ratio_r == 6'h08 || last_ratio_r == 6'h09))
    else $error("divide by 8 mode used a wrong ratio");

  a_fixed_three: assert property (@(posedge sys_clk) disable iff (srst)
    (div.tick && div.mode == 3'h7 && wrap) |=> (out_r && cnt_r == 6'h00) ##0 (ratio == 6'h03 || div.mode != 3'h7))
    else $error("fixed divide mode is not divide by three");

endmodule // psel_prescaler

// file: tb/psel_host.sv
// Purpose: Host model that programs the block through its register port.
// Assumes: Requests change on the falling edge and are taken on the next rising edge.
// Notes: Idle address shows the inverse of the last value; data is inverted after a write and keeps its value after a read.
module psel_host (
  input wire logic sys_clk, // System clock.
  output logic reg_wr, // Write strobe.
  output logic reg_rd, // Read strobe.
  output logic [9:0] reg_addr, // Register address.
  output logic [7:0] reg_wdata, // Write data.
  output logic status_lock, // Status lock level.
  input wire logic [7:0] reg_rdata // Read data.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h3e8;
    reg_wdata = 8'h5a;
    status_lock = 1'b0;
  end

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  task automatic lock(input logic v);
    @(negedge sys_clk);
    status_lock = v;
  endtask

  // A well-behaved host always drops the lock before a new selection.
  task automatic wr_sel(input logic [7:0] d);
    lock(1'b0);
    wr(10'h017, d);
  endtask
endmodule // psel_host

// file: tb/psel_top_tb.sv
// Purpose: Self-checking bench for the prescaler mode and status pin select block.
// Assumes: Inputs change on the falling edge; the prescaler tick is held high while measuring.
// Notes: Ratios are measured as the distance between two prescaler pulses.
module psel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psel_pkg::*;

  logic sys_clk, srst, vco_tick, swallow_nz, swallow_phase, presc_out, status_pin;
  logic reg_wr, reg_rd, status_lock;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, n;
  logic [8:0] src, one;
  logic [2:0] presc_mode;
  logic [5:0] status_sel;
  logic prev;
  int n_errors = 0;
  int samples_checked = 0;
  // Rows: mode, swallow nonzero, plus-one request, expected ratio.
  logic [12:0] prow [12] = '{
    {3'h4, 2'h3, 8'h09}, {3'h4, 2'h1, 8'h08},
    {3'h5, 2'h3, 8'h11}, {3'h5, 2'h2, 8'h10},
    {3'h6, 2'h3, 8'h21}, {3'h6, 2'h1, 8'h20},
    {3'h7, 2'h3, 8'h03}, {3'h7, 2'h0, 8'h03},
    {3'h0, 2'h3, 8'h01}, {3'h1, 2'h3, 8'h02}, {3'h2, 2'h3, 8'h03}, {3'h3, 2'h1, 8'h04}};
  // Rows: selection code, source raised for it (none for ground, prescaler and unlisted codes).
  logic [14:0] srow [13] = '{
    {6'h00, 9'h000}, {6'h01, 9'h001}, {6'h02, 9'h002}, {6'h03, 9'h004}, {6'h04, 9'h000},
    {6'h05, 9'h008}, {6'h06, 9'h010}, {6'h21, 9'h020}, {6'h22, 9'h040}, {6'h23, 9'h080},
    {6'h24, 9'h100}, {6'h07, 9'h000}, {6'h20, 9'h000}};

  psel_top psel_top_inst (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .status_lock, .vco_tick, .swallow_nz, .swallow_phase, .fb_div_out(src[0]),
    .ref_div_out(src[1]), .swallow_out(src[2]), .pfd_up(src[3]), .pfd_down(src[4]),
    .ref1_clk(src[5]), .ref2_clk(src[6]), .ref_sel_clk(src[7]), .ref_unsel_clk(src[8]),
    .presc_out, .presc_mode, .status_sel, .status_pin);
  psel_host psel_host_inst (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .status_lock,
    .reg_rdata);

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset;
    srst = 1'b1;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
  endtask

  // Bounded waits: a dead prescaler shows up as a ratio of 100.
  task automatic period(output logic [7:0] r);
    for (int i = 0; i < 100 && presc_out !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    r = 8'h01;
    while (presc_out !== 1'b1 && r < 8'd100) begin
      @(negedge sys_clk);
      r++;
    end
  endtask

  initial begin
    #200us;
    n_errors++;
    results();
  end

  initial begin
    {srst, vco_tick, swallow_nz, swallow_phase, src} = '0;
    do_reset();
    vco_tick = 1'b1;
    foreach (prow[i]) begin
      {swallow_nz, swallow_phase} = prow[i][9:8];
      psel_host_inst.wr(10'h016, {5'h00, prow[i][12:10]});
      psel_host_inst.rd(10'h016, rd);
      chk("mode readback", {5'h00, prow[i][12:10]}, rd);
      chk("mode port", {5'h00, prow[i][12:10]}, {5'h00, presc_mode});
      period(n);
      chk("ratio", prow[i][7:0], n);
      $display("test ratio row %0d done", i);
    end
    vco_tick = 1'b0;
    repeat (2) @(negedge sys_clk);
    foreach (srow[c]) begin
      psel_host_inst.wr_sel({srow[c][14:9], 2'h3});
      psel_host_inst.rd(10'h017, rd);
      chk("sel readback", {srow[c][14:9], 2'h0}, rd);
      chk("sel port", {2'h0, srow[c][14:9]}, {2'h0, status_sel});
      one = srow[c][8:0];
      src = one;
      repeat (2) @(negedge sys_clk);
      chk("pin on", {7'h00, one != 9'h000}, {7'h00, status_pin});
      src = ~one;
      repeat (2) @(negedge sys_clk);
      chk("pin off", 8'h00, {7'h00, status_pin});
      $display("test status code %0h done", srow[c][14:9]);
    end
    // Selection four mirrors the prescaler pulse one cycle late.
    psel_host_inst.wr_sel(8'h10);
    vco_tick = 1'b1;
    for (int i = 0; i < 40; i++) begin
      prev = presc_out;
      @(negedge sys_clk);
      chk("pin presc", {7'h00, prev}, {7'h00, status_pin});
    end
    psel_host_inst.lock(1'b1);
    psel_host_inst.wr(10'h017, 8'h04);
    psel_host_inst.rd(10'h017, rd);
    chk("locked sel", 8'h10, rd);
    psel_host_inst.rd(10'h018, rd);
    chk("unmapped", 8'h00, rd);
    $display("test lock and unmapped done");
    do_reset();
    chk("mode port reset", 8'h06, {5'h00, presc_mode});
    chk("sel port reset", 8'h00, {2'h0, status_sel});
    psel_host_inst.rd(10'h016, rd);
    chk("mode reset", 8'h06, rd);
    psel_host_inst.rd(10'h017, rd);
    chk("sel reset", 8'h00, rd);
    chk("pin reset", 8'h00, {7'h00, status_pin});
    $display("test reset done");
    results();
  end
endmodule // psel_top_tb
